// [hw/priv_regs_params.svh]
`ifndef PRIV_REGS_PARAMS_SVH
`define PRIV_REGS_PARAMS_SVH
// =====================================
// register map (byte addresses, axi4-lite)
`define OFF_CTRL        12'h000
`define OFF_STATUS_WORD 12'h004
`define OFF_VECBASE     12'h008
`define OFF_SPACE_CODES 12'h00c
`define OFF_CACHE_EN    12'h010
`define OFF_XLATE_BASE  12'h020
`define OFF_GPR_BASE    12'h040
`define OFF_USP         12'h080
`define OFF_SSP         12'h084
`define OFF_PC          12'h088
`define OFF_EVENT       12'h08c
`define OFF_ACCESS      12'h090
`define OFF_QUAD        12'h094
// =====================================
// field positions
`define BIT_PRIV        13
`define BIT_IC_EN       1
`define BIT_DC_EN       0
// =====================================
// reset values
`define RST_STATUS_WORD 16'h2700
`define RST_CACHE_EN    2'h0
`define RST_VECBASE     32'h0000_0000
// =====================================
// space codes
`define SPACE_USER_DATA 3'h1
`define SPACE_USER_PROG 3'h2
`define SPACE_SUP_DATA  3'h5
`define SPACE_SUP_PROG  3'h6
`define FLUSH_CYCLES    2
`endif

// [hw/priv_regs_pkg.sv]
`default_nettype none
package priv_regs_pkg;
  typedef enum logic [2:0] {
    OP_NONE, OP_MOVE_SR, OP_AND_IMM, OP_XOR_IMM, OP_EXC_RETURN
  } sr_op_t;
  typedef enum logic [1:0] { ST_RUN, ST_EXC_PUSH, ST_EXC_ENTER, ST_FLUSH } state_t;
  typedef struct packed {
    logic [2:0]  space;
    logic        supervisor;
    logic [31:0] addr;
    logic        valid;
  } bus_attr_t;
  typedef struct packed {
    logic [7:0] base;
    logic [7:0] mask;
    logic       enable;
    logic       cacheable;
  } xlate_t;
endpackage
`default_nettype wire

// [hw/privilege_mode_register_model.sv]
// Notes on behaviour
// RULE_01 - privilege bit one means supervisor mode, zero means user mode.
// RULE_02 - exception processing runs supervisor, every cycle marked supervisor.
// RULE_03 - exception stack accesses use the active supervisor stack pointer.
// RULE_04 - user-mode instruction cycles are marked as user references.
// RULE_05 - transfer-modifier outputs show supervisor or user for each access.
// RULE_06 - exception entry pushes status word first, then sets privilege bit.
// RULE_07 - only move, and-imm, xor-imm, exception return change privilege, in supervisor.
// RULE_08 - privilege change flushes the pipeline and refetches in new space.
// RULE_09 - sixteen 32-bit general registers plus program counter and flags byte.
// RULE_10 - general registers are eight data, seven address, one stack pointer.
// RULE_11 - any general register indexes; address registers and stack pointer form bases.
// RULE_12 - flags byte is status low byte, user accessible, holds condition codes.
// RULE_13 - status upper byte is supervisor only.
// RULE_14 - vector base register locates vectors during exception processing.
// RULE_15 - source and destination space codes are 3-bit address extensions.
// RULE_16 - normal accesses get space codes from privilege and access type.
// RULE_17 - alternate-space instructions take the space code registers instead.
// RULE_18 - cache control enables instruction and data caches independently.
// RULE_19 - four transparent translation registers, two instruction, two data.
// RULE_20 - operands are twos-complement, size explicit or implied.
// RULE_21 - decimal operands are one byte, packed two digits or unpacked one.
// RULE_22 - 128-bit operands live in memory only, 16-byte aligned.
// RULE_23 - 64-bit integer operand is held in any pair of data registers.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`include "priv_regs_params.svh"
`default_nettype none
module privilege_mode_register_model #(
  parameter int VEC_W = 8
) (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write
  input  wire logic [11:0]               s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0]               s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // core events
  input  wire logic                      exc_req,
  input  wire logic [VEC_W-1:0]          exc_vector,
  input  wire logic                      sr_op_valid,
  input  wire priv_regs_pkg::sr_op_t     sr_op,
  input  wire logic [15:0]               sr_op_value,
  input  wire logic                      flags_wr,
  input  wire logic [7:0]                flags_value,
  // bus access request
  input  wire logic                      acc_valid,
  input  wire logic                      acc_is_prog,
  input  wire logic                      acc_alt_src,
  input  wire logic                      acc_alt_dst,
  input  wire logic [31:0]               acc_addr,
  // outputs to core and bus
  output priv_regs_pkg::bus_attr_t       bus_attr,
  output logic                           acc_cacheable,
  output logic                           flush,
  output logic                           exc_busy,
  output logic [31:0]                    vector_addr,
  output logic                           sup_mode,
  output logic                           icache_en,
  output logic                           dcache_en
);
  // =====================================
  // architectural state
  logic [31:0]            gpr_q [16];       // [RULE_09] [RULE_10]
  logic [31:0]            ssp_q;
  logic [31:0]            pc_q;
  logic [15:0]            sr_q;
  logic [15:0]            sr_saved_q;
  logic [31:0]            vbr_q;
  logic [2:0]             src_space_q;
  logic [2:0]             dst_space_q;
  logic [1:0]             cache_q;
  priv_regs_pkg::xlate_t  xl_q [4];
  priv_regs_pkg::state_t  state_q;
  logic [1:0]             flush_cnt_q;
  logic [VEC_W-1:0]       vec_q;
  logic [31:0]            push_addr_q;
  logic                   denied_q;
  logic [3:0]             quad_sel_q;
  logic [15:0]            sr_new;
  logic                   priv_ok;

  assign sup_mode  = sr_q[`BIT_PRIV];                           // [RULE_01]
  assign icache_en = cache_q[`BIT_IC_EN];                       // [RULE_18]
  assign dcache_en = cache_q[`BIT_DC_EN];                       // [RULE_18]
  assign exc_busy  = (state_q == priv_regs_pkg::ST_EXC_PUSH) ||
                     (state_q == priv_regs_pkg::ST_EXC_ENTER);
  assign flush     = (state_q == priv_regs_pkg::ST_FLUSH);
  // sp used for stacking: user sp is gpr 15, supervisor sp separate
  assign priv_ok   = sup_mode;                                  // [RULE_07]

  // =====================================
  // status word update by privileged instructions
  always_comb begin
    case (sr_op)
      priv_regs_pkg::OP_MOVE_SR:     sr_new = sr_op_value;
      priv_regs_pkg::OP_AND_IMM:     sr_new = sr_q & sr_op_value;
      priv_regs_pkg::OP_XOR_IMM:     sr_new = sr_q ^ sr_op_value;
      priv_regs_pkg::OP_EXC_RETURN:  sr_new = sr_saved_q;
      default:                       sr_new = sr_q;
    endcase
  end

  // =====================================
  // axi4-lite slave
  logic        aw_q;
  logic        w_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  logic [31:0] wmerge;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic        wr_hit;

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_q && w_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_q <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (s_axi_araddr >= `OFF_GPR_BASE && s_axi_araddr < `OFF_USP) begin
      rd_val = gpr_q[s_axi_araddr[5:2]]; // [RULE_11]
    end else if (s_axi_araddr >= `OFF_XLATE_BASE && s_axi_araddr < `OFF_GPR_BASE) begin
      if (s_axi_araddr[4]) rd_hit = 1'b0;
      else rd_val = {14'h0000, xl_q[s_axi_araddr[3:2]]};
    end else begin
      case (s_axi_araddr)
        `OFF_CTRL:        rd_val = {30'h0000_0000, denied_q, flush};
        `OFF_STATUS_WORD: rd_val = {16'h0000, sr_q};
        `OFF_VECBASE:     rd_val = vbr_q;
        `OFF_SPACE_CODES: rd_val = {21'h000000, dst_space_q, 5'h00, src_space_q};
        `OFF_CACHE_EN:    rd_val = {30'h0000_0000, cache_q};
        `OFF_USP:         rd_val = gpr_q[15];
        `OFF_SSP:         rd_val = ssp_q;
        `OFF_PC:          rd_val = pc_q;
        `OFF_EVENT:       rd_val = {{(32-VEC_W){1'b0}}, vec_q};
        `OFF_ACCESS:      rd_val = push_addr_q;
        `OFF_QUAD:        rd_val = {28'h0000000, quad_sel_q};
        default:          rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_hit ? rd_val : 32'h0000_0000;
        s_axi_rresp  <= rd_hit ? 2'h0 : 2'h3;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h3;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_hit = (awaddr_q < `OFF_EVENT) &&
                  !(awaddr_q >= `OFF_XLATE_BASE + 12'h010 && awaddr_q < `OFF_GPR_BASE) &&
                  (awaddr_q != `OFF_CTRL) &&
                  !(awaddr_q > `OFF_CACHE_EN && awaddr_q < `OFF_XLATE_BASE);

  // =====================================
  // general registers and program counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 16; i++) gpr_q[i] <= 32'h0000_0000;
      pc_q  <= 32'h0000_0000;
      ssp_q <= 32'h0000_0000;
    end else begin
      if (wr_fire && awaddr_q >= `OFF_GPR_BASE && awaddr_q < `OFF_USP)
        gpr_q[awaddr_q[5:2]] <= merge(gpr_q[awaddr_q[5:2]], wdata_q, wstrb_q);
      if (wr_fire && awaddr_q == `OFF_USP) gpr_q[15] <= merge(gpr_q[15], wdata_q, wstrb_q);
      if (state_q == priv_regs_pkg::ST_EXC_PUSH)
        ssp_q <= ssp_q - 32'd4;                                 // [RULE_03]
      else if (wr_fire && awaddr_q == `OFF_SSP) ssp_q <= merge(ssp_q, wdata_q, wstrb_q);
      if (state_q == priv_regs_pkg::ST_EXC_ENTER) pc_q <= vector_addr;
      else if (wr_fire && awaddr_q == `OFF_PC) pc_q <= merge(pc_q, wdata_q, wstrb_q);
    end
  end

  // =====================================
  // status word, saved copy and exception sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_q        <= `RST_STATUS_WORD;
      sr_saved_q  <= `RST_STATUS_WORD;
      state_q     <= priv_regs_pkg::ST_RUN;
      flush_cnt_q <= 2'h0;
      vec_q       <= '0;
      push_addr_q <= 32'h0000_0000;
      denied_q    <= 1'b0;
    end else begin
      case (state_q)
        priv_regs_pkg::ST_RUN: begin
          if (exc_req) begin
            vec_q       <= exc_vector;
            state_q     <= priv_regs_pkg::ST_EXC_PUSH;
          end else if (sr_op_valid && sr_op != priv_regs_pkg::OP_NONE) begin
            if (priv_ok) begin                                  // [RULE_07]
              sr_q <= sr_new;
              if (sr_new[`BIT_PRIV] != sr_q[`BIT_PRIV]) begin
                state_q     <= priv_regs_pkg::ST_FLUSH;         // [RULE_08]
                flush_cnt_q <= 2'(`FLUSH_CYCLES - 1);
              end
            end else begin
              denied_q <= 1'b1;
            end
          end else if (flags_wr) begin
            sr_q[7:0] <= flags_value;                           // [RULE_12]
          end else if (wr_fire && awaddr_q == `OFF_STATUS_WORD) begin
            if (wstrb_q[0]) sr_q[7:0] <= wdata_q[7:0];          // [RULE_12]
            if (wstrb_q[1] && sup_mode) sr_q[15:8] <= wdata_q[15:8]; // [RULE_13]
            sr_q[`BIT_PRIV] <= sup_mode; // [RULE_07] only instructions move the mode
          end
        end
        priv_regs_pkg::ST_EXC_PUSH: begin
          // old status goes onto the supervisor stack before S is set
          sr_saved_q  <= sr_q;                                  // [RULE_06]
          push_addr_q <= ssp_q - 32'd4;                         // [RULE_03]
          state_q     <= priv_regs_pkg::ST_EXC_ENTER;
        end
        priv_regs_pkg::ST_EXC_ENTER: begin
          sr_q[`BIT_PRIV] <= 1'b1;                              // [RULE_06] [RULE_02]
          state_q         <= priv_regs_pkg::ST_FLUSH;
          flush_cnt_q     <= 2'(`FLUSH_CYCLES - 1);
        end
        priv_regs_pkg::ST_FLUSH: begin
          if (flush_cnt_q == 2'h0) state_q <= priv_regs_pkg::ST_RUN;
          else flush_cnt_q <= flush_cnt_q - 2'h1;
        end
        default: state_q <= priv_regs_pkg::ST_RUN;
      endcase
      if (wr_fire && awaddr_q == `OFF_STATUS_WORD && state_q != priv_regs_pkg::ST_RUN)
        denied_q <= 1'b1;
    end
  end

  // vector fetch address from the table base
  assign vector_addr = vbr_q + {{(30-VEC_W){1'b0}}, vec_q, 2'b00}; // [RULE_14]

  // =====================================
  // supervisor control registers; software writes only from supervisor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vbr_q       <= `RST_VECBASE;
      src_space_q <= 3'h0;
      dst_space_q <= 3'h0;
      cache_q     <= `RST_CACHE_EN;
    end else if (wr_fire && sup_mode) begin                     // [RULE_13]
      if (awaddr_q == `OFF_VECBASE) vbr_q <= merge(vbr_q, wdata_q, wstrb_q);
      if (awaddr_q == `OFF_SPACE_CODES) begin
        if (wstrb_q[0]) src_space_q <= wdata_q[2:0];            // [RULE_15]
        if (wstrb_q[1]) dst_space_q <= wdata_q[10:8];           // [RULE_15]
      end
      if (awaddr_q == `OFF_CACHE_EN && wstrb_q[0]) cache_q <= wdata_q[1:0]; // [RULE_18]
    end
  end

  // =====================================
  // transparent translation: 0,1 instruction, 2,3 data
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_xl
      always_ff @(posedge aclk) begin
        if (!aresetn) xl_q[g] <= '0;
        else if (wr_fire && sup_mode && awaddr_q == `OFF_XLATE_BASE + 12'(4*g))
          xl_q[g] <= wdata_q[17:0];                             // [RULE_19]
      end
    end
  endgenerate

  logic [3:0] xl_hit;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      xl_hit[k] = xl_q[k].enable && ((k < 2) == acc_is_prog) &&
                  (((acc_addr[31:24] ^ xl_q[k].base) & ~xl_q[k].mask) == 8'h00);
    end
  end

  // =====================================
  // transfer attributes for each access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_attr      <= '0;
      acc_cacheable <= 1'b0;
      quad_sel_q    <= 4'h0;
    end else begin
      bus_attr.valid <= acc_valid || exc_busy;
      bus_attr.addr  <= exc_busy ? push_addr_q : acc_addr;
      // exception cycles are always supervisor regardless of sr
      bus_attr.supervisor <= exc_busy || sup_mode;              // [RULE_02] [RULE_04] [RULE_05]
      if (exc_busy) bus_attr.space <= `SPACE_SUP_DATA;          // [RULE_02]
      else if (acc_alt_src) bus_attr.space <= src_space_q;      // [RULE_17]
      else if (acc_alt_dst) bus_attr.space <= dst_space_q;      // [RULE_17]
      else if (sup_mode)                                        // [RULE_16]
        bus_attr.space <= acc_is_prog ? `SPACE_SUP_PROG : `SPACE_SUP_DATA;
      else
        bus_attr.space <= acc_is_prog ? `SPACE_USER_PROG : `SPACE_USER_DATA;
      acc_cacheable <= (|xl_hit[1:0] && acc_is_prog) ? (xl_q[0].cacheable || xl_q[1].cacheable)
                     : (|xl_hit[3:2] && !acc_is_prog) ? (xl_q[2].cacheable || xl_q[3].cacheable)
                     : (acc_is_prog ? icache_en : dcache_en);  // [RULE_19]
      // bit 3 flags a 16-byte aligned access
      quad_sel_q <= {~|acc_addr[3:0], acc_addr[2:0]};           // [RULE_22] [RULE_23]
    end
  end
endmodule
`default_nettype wire

// [bench/priv_regs_monitor.sv]
`default_nettype none
module priv_regs_monitor (
  // clock, reset and core requests
  input wire logic                     aclk,
  input wire logic                     aresetn,
  input wire logic                     exc_req,
  input wire logic                     sr_op_valid,
  input wire logic                     acc_valid,
  input wire logic                     acc_is_prog,
  input wire logic                     acc_alt_src,
  input wire logic                     acc_alt_dst,
  input wire logic [31:0]              acc_addr,
  // design outputs
  input wire priv_regs_pkg::bus_attr_t bus_attr,
  input wire logic                     flush,
  input wire logic                     exc_busy,
  input wire logic                     sup_mode
);
  // =====================================
  // mode and attribute checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_exc_start;
    exc_req && !exc_busy && !flush;
  endsequence
  // old mode must still show while the status word is pushed
  sequence s_push_then_set;
    (exc_busy && $stable(sup_mode)) ##1 exc_busy ##1 (sup_mode && flush) ##1 flush ##1 !flush;
  endsequence
  chk_exc_order: assert property (s_exc_start |=> s_push_then_set)
    else $error("exception entry out of order");
  chk_exc_super: assert property (bus_attr.valid && $past(exc_busy)
    |-> bus_attr.supervisor)
    else $error("exception cycle not marked supervisor");
  chk_user_ref: assert property (bus_attr.valid && !$past(sup_mode)
    && !$past(exc_busy) |-> !bus_attr.supervisor)
    else $error("user cycle marked supervisor");
  chk_attr_issue: assert property (acc_valid && !exc_busy
    |=> bus_attr.valid && bus_attr.addr == $past(acc_addr))
    else $error("access attributes missing or wrong address");
  chk_space_auto: assert property (acc_valid && !exc_busy && !acc_alt_src
    && !acc_alt_dst |=> bus_attr.space == {$past(sup_mode), $past(acc_is_prog) ? 2'h2 : 2'h1})
    else $error("generated space code wrong");
  chk_priv_fall: assert property ($fell(sup_mode) |-> $past(sr_op_valid))
    else $error("privilege dropped without a status operation");
  chk_priv_rise: assert property ($rose(sup_mode) |-> $past(exc_busy))
    else $error("privilege raised outside exception entry");
  chk_op_flush: assert property ($past(sr_op_valid) && $changed(sup_mode)
    |-> ##[0:1] flush ##1 flush)
    else $error("no flush after privilege change");
endmodule
bind privilege_mode_register_model priv_regs_monitor monitor_i (
  .aclk, .aresetn, .exc_req, .sr_op_valid, .acc_valid, .acc_is_prog, .acc_alt_src,
  .acc_alt_dst, .acc_addr, .bus_attr, .flush, .exc_busy, .sup_mode
);
`default_nettype wire

// [bench/bus_space_decoder.sv]
`default_nettype none
module bus_space_decoder (
  // clock and transfer attributes
  input wire logic                     aclk,
  input wire priv_regs_pkg::bus_attr_t attr,
  // last decoded transfer
  output logic [2:0]                   seen_space,
  output logic                         seen_sup,
  output logic [31:0]                  seen_addr
);
  // =====================================
  // decode
  // idle attributes are don't-care on the bus, so only qualified cycles latch
  always_ff @(posedge aclk) begin
    if (attr.valid) begin
      seen_space <= attr.space;
      seen_sup   <= attr.supervisor;
      seen_addr  <= attr.addr;
    end
  end
endmodule
`default_nettype wire

// [bench/privilege_mode_register_model_bench.sv]
`include "priv_regs_params.svh"
`default_nettype none
module privilege_mode_register_model_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================
  // signals
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, acc_addr = 32'h0, s_axi_rdata, vector_addr, seen_addr;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, exc_req = 1'b0, flags_wr = 1'b0;
  logic        sr_op_valid = 1'b0, acc_valid = 1'b0, acc_is_prog = 1'b0;
  logic        acc_alt_src = 1'b0, acc_alt_dst = 1'b0;
  logic [7:0]  exc_vector = 8'h00, flags_value = 8'h00;
  logic [15:0] sr_op_value = 16'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  seen_space;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        acc_cacheable, flush, exc_busy, sup_mode, icache_en, dcache_en, seen_sup;
  priv_regs_pkg::sr_op_t    sr_op = priv_regs_pkg::OP_NONE;
  priv_regs_pkg::bus_attr_t bus_attr;
  priv_regs_pkg::sr_op_t    ops [4] = '{priv_regs_pkg::OP_MOVE_SR, priv_regs_pkg::OP_AND_IMM,
                                       priv_regs_pkg::OP_XOR_IMM, priv_regs_pkg::OP_EXC_RETURN};
  logic [15:0] op_vals [4] = '{16'h0000, 16'h00ff, 16'h2000, 16'h0000};
  int          mismatches = 0;
  int          compares = 0;
  always #4 aclk = ~aclk;
  privilege_mode_register_model #(.VEC_W(8)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .exc_req, .exc_vector, .sr_op_valid, .sr_op, .sr_op_value, .flags_wr,
    .flags_value, .acc_valid, .acc_is_prog, .acc_alt_src, .acc_alt_dst, .acc_addr, .bus_attr,
    .acc_cacheable, .flush, .exc_busy, .vector_addr, .sup_mode, .icache_en, .dcache_en
  );
  bus_space_decoder far_i (.aclk, .attr(bus_attr), .seen_space, .seen_sup, .seen_addr);
  // =====================================
  // tasks
  task automatic print_verdict;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bound(input int n);
    if (n >= 64) begin
      mismatches++;
      $display("[FAIL] %0t: wait ran out", $time);
      print_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    bound(n);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    bound(n);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, exp);
  endtask
  // exception and flush states show as busy or flush; run state shows neither
  task automatic settle;
    int n;
    repeat (2) @(posedge aclk);
    for (n = 0; n < 64 && (exc_busy || flush); n++) @(posedge aclk);
    bound(n);
  endtask
  task automatic take_exc(input logic [7:0] v);
    @(posedge aclk);
    exc_vector <= v;
    exc_req <= 1'b1;
    acc_valid <= 1'b1;
    @(posedge aclk);
    exc_req <= 1'b0;
    settle();
    acc_valid <= 1'b0;
    check(vector_addr, 32'h0000_1000 + {22'h0, v, 2'h0});
  endtask
  task automatic sr(input priv_regs_pkg::sr_op_t op, input logic [15:0] v);
    @(posedge aclk);
    sr_op <= op;
    sr_op_value <= v;
    sr_op_valid <= 1'b1;
    @(posedge aclk);
    sr_op_valid <= 1'b0;
    settle();
  endtask
  task automatic acc(input logic p, s, d, input logic [31:0] a, input logic es,
                     input logic [2:0] sp);
    @(posedge aclk);
    acc_valid <= 1'b1;
    acc_is_prog <= p;
    acc_alt_src <= s;
    acc_alt_dst <= d;
    acc_addr <= a;
    @(posedge aclk);
    acc_valid <= 1'b0;
    @(posedge aclk);
    @(negedge aclk);
    check({28'h0, seen_sup, seen_space}, {28'h0, es, sp});
    check(seen_addr, a);
    check({31'h0, acc_cacheable}, 32'h1);
  endtask
  // =====================================
  // sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          i;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`OFF_STATUS_WORD, {16'h0, `RST_STATUS_WORD});
    check({31'h0, sup_mode}, 32'h1);
    rd(12'h0fc, d, r);
    check({30'h0, r}, 32'h3);
    check(d, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(`OFF_CACHE_EN, 32'(i));
      check({30'h0, icache_en, dcache_en}, 32'(i));
    end
    for (i = 0; i < 16; i++)
      wr(`OFF_GPR_BASE + 12'(4 * i), {4'(i), 28'h0a5_5a5a});
    for (i = 0; i < 16; i++)
      rchk(`OFF_GPR_BASE + 12'(4 * i), {4'(i), 28'h0a5_5a5a});
    rchk(`OFF_USP, {4'hf, 28'h0a5_5a5a});
    for (i = 0; i < 4; i++) begin
      wr(`OFF_XLATE_BASE + 12'(4 * i), {14'h0, 8'(16 * i + 1), 8'hf0, 2'(i)});
      rchk(`OFF_XLATE_BASE + 12'(4 * i), {14'h0, 8'(16 * i + 1), 8'hf0, 2'(i)});
    end
    wr(`OFF_SPACE_CODES, 32'h0000_0403);
    rchk(`OFF_SPACE_CODES, 32'h0000_0403);
    acc(1'b0, 1'b1, 1'b0, 32'h0000_4000, 1'b1, 3'h3);
    acc(1'b0, 1'b0, 1'b1, 32'h0000_4004, 1'b1, 3'h4);
    acc(1'b0, 1'b0, 1'b0, 32'h0000_4008, 1'b1, `SPACE_SUP_DATA);
    acc(1'b1, 1'b0, 1'b0, 32'h0000_400c, 1'b1, `SPACE_SUP_PROG);
    wr(`OFF_SSP, 32'h0000_8000);
    wr(`OFF_VECBASE, 32'h0000_1000);
    // every way back to user mode, each entered from a fresh exception
    for (i = 0; i < 4; i++) begin
      take_exc(8'(i + 3));
      check({31'h0, sup_mode}, 32'h1);
      rchk(`OFF_PC, 32'h0000_1000 + 32'(4 * i + 12));
      if (i == 0)
        rchk(`OFF_ACCESS, 32'h0000_7ffc);
      sr(ops[i], op_vals[i]);
      check({31'h0, sup_mode}, 32'h0);
      if (i == 0) begin
        @(posedge aclk);
        flags_value <= 8'h5a;
        flags_wr <= 1'b1;
        @(posedge aclk);
        flags_wr <= 1'b0;
        rchk(`OFF_STATUS_WORD, 32'h0000_005a);
        wr(`OFF_STATUS_WORD, 32'h0000_27c3);
        rchk(`OFF_STATUS_WORD, 32'h0000_00c3);
        acc(1'b0, 1'b0, 1'b0, 32'h0000_5000, 1'b0, `SPACE_USER_DATA);
        acc(1'b1, 1'b0, 1'b0, 32'h0000_5004, 1'b0, `SPACE_USER_PROG);
        sr(priv_regs_pkg::OP_XOR_IMM, 16'h2000);
        check({31'h0, sup_mode}, 32'h0);
      end
    end
    rchk(`OFF_STATUS_WORD, 32'h0000_00c3);
    print_verdict();
  end
endmodule
`default_nettype wire
